// file: src/adc_seq_pkg.sv
// Shared constants and types for the converter sequencer
package adc_seq_pkg;
    localparam int ADDR_W = 6;
    localparam int DATA_W = 16;
    localparam int RESULT_W = 10;
    localparam int BUF_DEPTH = 16;
    localparam int PTR_W = 4;
    localparam int INPUT_COUNT = 6;
    localparam int CHAN_COUNT = 4;
    localparam int COUNT_W = 7;

    localparam logic [5:0] OFF_CONTROL_1 = 6'h00;
    localparam logic [5:0] OFF_CONTROL_2 = 6'h01;
    localparam logic [5:0] OFF_ZERO_INPUT = 6'h02;
    localparam logic [5:0] OFF_TRIO_INPUT = 6'h03;
    localparam logic [5:0] OFF_PIN_CONFIG = 6'h04;
    localparam logic [5:0] OFF_STATUS = 6'h05;
    localparam logic [5:0] OFF_RESULT_BASE = 6'h10;

    localparam int MODULE_ON_BIT = 15;
    localparam int SIMULTANEOUS_SAMPLING_BIT = 3;
    localparam int DONE_BIT = 0;
    localparam int CHAN_SEL_LSB = 8;
    localparam int ACTIVE_HALF_BIT = 7;
    localparam int SEQ_IRQ_LSB = 2;
    localparam int SPLIT_BIT = 1;
    localparam int ALT_BIT = 0;
    localparam int CH0_NEG_B_BIT = 15;
    localparam int CH0_POS_B_LSB = 8;
    localparam int CH0_NEG_A_BIT = 7;
    localparam int CH0_POS_A_LSB = 0;
    localparam int TRIO_NEG_B_LSB = 9;
    localparam int TRIO_POS_B_BIT = 8;
    localparam int TRIO_NEG_A_LSB = 1;
    localparam int TRIO_POS_A_BIT = 0;
    localparam int IRQ_FLAG_BIT = 0;

    localparam logic [15:0] CONTROL_1_WMASK = 16'h8008;
    localparam logic [15:0] CONTROL_2_WMASK = 16'h033f;
    localparam logic [15:0] ZERO_INPUT_WMASK = 16'h9f9f;
    localparam logic [15:0] TRIO_INPUT_WMASK = 16'h0707;
    localparam logic [15:0] PIN_CONFIG_WMASK = 16'h003f;
    localparam logic [15:0] REG_RESET = 16'h0000;

    typedef enum logic [0:0] {ST_IDLE, ST_CONVERT} seq_state_t;
endpackage

// file: src/adc_sequencer.sv
// Converter sequencer: registers, conversion count, buffer fill, inputs
//
// Contract
// - Clearing module on stops all sampling and conversion until set again.
// - Power-down halts the block; its release leaves every register default.
// - During power-down the shared pins are digital; pin config is ignored.
// - Module off mid-conversion abandons it; no partial result is stored.
// - Each finished result goes to the 16-word buffer in finishing order.
// - Interrupt after N, 2N or 4N conversions per mode and sequence field.
// - Done sets with the interrupt flag; clears when a new sequence starts.
// - Split mode fills two 8-word halves, swapping at each interrupt.
// - Unsplit mode uses all 16 words; word 0 refilled after interrupt.
// - Active-half bit reads 0 filling lower half, 1 filling upper half.
// - Without alternate mode only set A selections route the inputs.
// - Ch0 positive picks inputs 0-5, negative ground or 1; trio negatives ground.
// - Alternate mode swaps set A and B per sweep, starting with A.
// - Each interrupt restarts sequencing from its first step and set A.
// - Channel count 00 is channel 0, 01 channels 0-1, 1x all four.
// - Trio positive select 0 gives inputs 0,1,2; 1 gives inputs 3,4,5.
// - Ch0 positive value is the input number; negative 0 is ground.
`timescale 1ns/1ps
module adc_sequencer #(
    parameter int RESULT_W = adc_seq_pkg::RESULT_W,
    parameter int BUF_DEPTH = adc_seq_pkg::BUF_DEPTH
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic converter_power_down,
    input wire logic [5:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [15:0] reg_rdata,
    input wire logic conv_trigger,
    input wire logic conv_done,
    input wire logic [RESULT_W-1:0] conv_result,
    output logic conv_active,
    output logic [1:0] conv_channel,
    output logic [11:0] sh_pos_input,
    output logic [3:0] sh_pos_valid,
    output logic [3:0] sh_neg_input1,
    output logic [5:0] pin_analog_en,
    output logic conversion_irq_flag,
    output logic conversion_done
);
    localparam int PW = adc_seq_pkg::PTR_W;
    localparam int CW = adc_seq_pkg::COUNT_W;

    logic soft_rst_n;
    logic [15:0] control_1_reg;
    logic [15:0] control_2_reg;
    logic [15:0] zero_channel_input_reg;
    logic [15:0] trio_channel_input_reg;
    logic [15:0] pin_config_reg;
    logic [15:0] reg_rdata_reg;
    adc_seq_pkg::seq_state_t state_reg;
    adc_seq_pkg::seq_state_t state_next;
    logic [1:0] chan_idx_reg;
    logic [CW-1:0] conv_count_reg;
    logic [PW-1:0] wr_ptr_reg;
    logic active_half_reg;
    logic use_set_b_reg;
    logic done_reg;
    logic irq_flag_reg;

    logic module_on;
    logic simultaneous_sampling;
    logic [1:0] channel_count_sel;
    logic [3:0] sequences_per_irq;
    logic split_buffer_mode;
    logic alternate_input_en;
    logic [5:0] pin_config_bits;
    logic [2:0] chan_total;
    logic [CW-1:0] target_count;
    logic seq_start;
    logic result_write;
    logic irq_event;
    logic sweep_end;
    logic last_of_seq;
    logic [RESULT_W-1:0] buf_rdata;
    logic irq_clear;

    // Power-down holds every register but the pin-function one at its default
    assign soft_rst_n = reset_n && !converter_power_down;

    assign module_on = control_1_reg[adc_seq_pkg::MODULE_ON_BIT];
    assign simultaneous_sampling = control_1_reg[adc_seq_pkg::SIMULTANEOUS_SAMPLING_BIT];
    assign channel_count_sel =
        control_2_reg[adc_seq_pkg::CHAN_SEL_LSB +: 2];
    assign sequences_per_irq =
        control_2_reg[adc_seq_pkg::SEQ_IRQ_LSB +: 4];
    assign split_buffer_mode = control_2_reg[adc_seq_pkg::SPLIT_BIT];
    assign alternate_input_en = control_2_reg[adc_seq_pkg::ALT_BIT];
    assign pin_config_bits = pin_config_reg[5:0];

    // Channels per sweep from the channel-count field
    always_comb begin
        if (channel_count_sel == 2'h0) begin
            chan_total = 3'h1;
        end else if (channel_count_sel == 2'h1) begin
            chan_total = 3'h2;
        end else begin
            chan_total = 3'h4;
        end
    end

    // Conversions between interrupts
    always_comb begin
        if (simultaneous_sampling && chan_total != 3'h1) begin
            target_count = CW'({3'h0, sequences_per_irq} + 7'h01)
                           * CW'(chan_total);
        end else begin
            target_count = CW'({3'h0, sequences_per_irq} + 7'h01);
        end
    end

    // A trigger is only taken while on and idle
    assign seq_start = (state_reg == adc_seq_pkg::ST_IDLE) && module_on
                       && conv_trigger;

    // Results are stored only while the module stays on
    assign result_write = (state_reg == adc_seq_pkg::ST_CONVERT)
                          && module_on && conv_done;

    assign irq_event = result_write
                       && (conv_count_reg + 7'h01 == target_count);

    assign sweep_end = (3'({1'b0, chan_idx_reg}) + 3'h1 == chan_total);

    // Sequential: one conversion per trigger; simultaneous: whole sweep
    assign last_of_seq = !simultaneous_sampling || sweep_end || irq_event;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            adc_seq_pkg::ST_IDLE: begin
                if (seq_start) begin
                    state_next = adc_seq_pkg::ST_CONVERT;
                end
            end
            adc_seq_pkg::ST_CONVERT: begin
                if (!module_on) begin
                    state_next = adc_seq_pkg::ST_IDLE;
                end else if (conv_done && last_of_seq) begin
                    state_next = adc_seq_pkg::ST_IDLE;
                end
            end
            default: state_next = adc_seq_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!soft_rst_n) begin
            state_reg <= adc_seq_pkg::ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Channel within the sweep and the input set in use
    always_ff @(posedge clock) begin
        if (!soft_rst_n) begin
            chan_idx_reg <= 2'h0;
            use_set_b_reg <= 1'b0;
        end else if (irq_event) begin
            chan_idx_reg <= 2'h0;
            use_set_b_reg <= 1'b0;
        end else if (result_write) begin
            if (sweep_end) begin
                chan_idx_reg <= 2'h0;
                use_set_b_reg <= alternate_input_en
                                 && !use_set_b_reg;
            end else begin
                chan_idx_reg <= chan_idx_reg + 2'h1;
            end
        end else if (!alternate_input_en) begin
            use_set_b_reg <= 1'b0;
        end
    end

    // Conversions since the last interrupt
    always_ff @(posedge clock) begin
        if (!soft_rst_n) begin
            conv_count_reg <= '0;
        end else if (irq_event) begin
            conv_count_reg <= '0;
        end else if (result_write) begin
            conv_count_reg <= conv_count_reg + 7'h01;
        end
    end

    // Write pointer and the half being filled
    always_ff @(posedge clock) begin
        if (!soft_rst_n) begin
            wr_ptr_reg <= '0;
            active_half_reg <= 1'b0;
        end else if (irq_event) begin
            if (split_buffer_mode) begin
                active_half_reg <= !active_half_reg;
                wr_ptr_reg <= {!active_half_reg, 3'h0};
            end else begin
                active_half_reg <= 1'b0;
                wr_ptr_reg <= '0;
            end
        end else if (result_write) begin
            if (split_buffer_mode) begin
                wr_ptr_reg <= {active_half_reg,
                               wr_ptr_reg[2:0] + 3'h1};
            end else begin
                wr_ptr_reg <= wr_ptr_reg + 4'h1;
            end
        end else if (!split_buffer_mode && active_half_reg) begin
            active_half_reg <= 1'b0;
        end
    end

    // Done flag: set with the interrupt, set wins over sequence start
    always_ff @(posedge clock) begin
        if (!soft_rst_n) begin
            done_reg <= 1'b0;
        end else if (irq_event) begin
            done_reg <= 1'b1;
        end else if (seq_start) begin
            done_reg <= 1'b0;
        end
    end

    // Interrupt flag: write one to clear, set wins
    assign irq_clear = reg_write && (reg_addr == adc_seq_pkg::OFF_STATUS)
                       && reg_wdata[adc_seq_pkg::IRQ_FLAG_BIT];

    always_ff @(posedge clock) begin
        if (!soft_rst_n) begin
            irq_flag_reg <= 1'b0;
        end else if (irq_event) begin
            irq_flag_reg <= 1'b1;
        end else if (irq_clear) begin
            irq_flag_reg <= 1'b0;
        end
    end

    // Register writes
    always_ff @(posedge clock) begin
        if (!soft_rst_n) begin
            control_1_reg <= adc_seq_pkg::REG_RESET;
            control_2_reg <= adc_seq_pkg::REG_RESET;
            zero_channel_input_reg <= adc_seq_pkg::REG_RESET;
            trio_channel_input_reg <= adc_seq_pkg::REG_RESET;
            pin_config_reg <= adc_seq_pkg::REG_RESET;
        end else if (reg_write) begin
            if (reg_addr == adc_seq_pkg::OFF_CONTROL_1) begin
                control_1_reg <= reg_wdata & adc_seq_pkg::CONTROL_1_WMASK;
            end else if (reg_addr == adc_seq_pkg::OFF_CONTROL_2) begin
                control_2_reg <= reg_wdata & adc_seq_pkg::CONTROL_2_WMASK;
            end else if (reg_addr == adc_seq_pkg::OFF_ZERO_INPUT) begin
                zero_channel_input_reg <=
                    reg_wdata & adc_seq_pkg::ZERO_INPUT_WMASK;
            end else if (reg_addr == adc_seq_pkg::OFF_TRIO_INPUT) begin
                trio_channel_input_reg <=
                    reg_wdata & adc_seq_pkg::TRIO_INPUT_WMASK;
            end else if (reg_addr == adc_seq_pkg::OFF_PIN_CONFIG) begin
                pin_config_reg <= reg_wdata & adc_seq_pkg::PIN_CONFIG_WMASK;
            end
        end
    end

    // Register reads, data in the following cycle
    always_ff @(posedge clock) begin
        if (!soft_rst_n) begin
            reg_rdata_reg <= adc_seq_pkg::REG_RESET;
        end else if (reg_read) begin
            if (reg_addr == adc_seq_pkg::OFF_CONTROL_1) begin
                reg_rdata_reg <= control_1_reg;
                reg_rdata_reg[adc_seq_pkg::DONE_BIT] <= done_reg;
            end else if (reg_addr == adc_seq_pkg::OFF_CONTROL_2) begin
                reg_rdata_reg <= control_2_reg;
                reg_rdata_reg[adc_seq_pkg::ACTIVE_HALF_BIT] <=
                    active_half_reg;
            end else if (reg_addr == adc_seq_pkg::OFF_ZERO_INPUT) begin
                reg_rdata_reg <= zero_channel_input_reg;
            end else if (reg_addr == adc_seq_pkg::OFF_TRIO_INPUT) begin
                reg_rdata_reg <= trio_channel_input_reg;
            end else if (reg_addr == adc_seq_pkg::OFF_PIN_CONFIG) begin
                reg_rdata_reg <= pin_config_reg;
            end else if (reg_addr == adc_seq_pkg::OFF_STATUS) begin
                reg_rdata_reg <= 16'({irq_flag_reg});
            end else if (reg_addr[5:4] == adc_seq_pkg::OFF_RESULT_BASE[5:4])
            begin
                reg_rdata_reg <= 16'(buf_rdata);
            end else begin
                reg_rdata_reg <= 16'h0000;
            end
        end else begin
            reg_rdata_reg <= 16'h0000;
        end
    end

    assign reg_rdata = reg_rdata_reg;

    result_buffer #(
        .WIDTH(RESULT_W),
        .DEPTH(BUF_DEPTH),
        .PTR_W(PW)
    ) u_result_buffer (
        .clock(clock),
        .soft_rst_n(soft_rst_n),
        .write_en(result_write),
        .write_index(wr_ptr_reg),
        .write_data(conv_result),
        .read_index(reg_addr[PW-1:0]),
        .read_data(buf_rdata)
    );

    input_router #(
        .CHANS(adc_seq_pkg::CHAN_COUNT)
    ) u_input_router (
        .clock(clock),
        .soft_rst_n(soft_rst_n),
        .use_set_b(use_set_b_reg),
        .ch0_pos_select_a(
            zero_channel_input_reg[adc_seq_pkg::CH0_POS_A_LSB +: 5]),
        .ch0_neg_select_a(
            zero_channel_input_reg[adc_seq_pkg::CH0_NEG_A_BIT]),
        .ch0_pos_select_b(
            zero_channel_input_reg[adc_seq_pkg::CH0_POS_B_LSB +: 5]),
        .ch0_neg_select_b(
            zero_channel_input_reg[adc_seq_pkg::CH0_NEG_B_BIT]),
        .trio_pos_select_a(
            trio_channel_input_reg[adc_seq_pkg::TRIO_POS_A_BIT]),
        .trio_pos_select_b(
            trio_channel_input_reg[adc_seq_pkg::TRIO_POS_B_BIT]),
        .sh_pos_input(sh_pos_input),
        .sh_pos_valid(sh_pos_valid),
        .sh_neg_input1(sh_neg_input1)
    );

    // Pin function: analog unless configured digital or powered down
    logic [5:0] pin_analog_reg;

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            pin_analog_reg <= 6'h3f;
        end else if (converter_power_down) begin
            pin_analog_reg <= 6'h00;
        end else begin
            pin_analog_reg <= ~pin_config_bits;
        end
    end

    assign pin_analog_en = pin_analog_reg;
    assign conv_active = (state_reg == adc_seq_pkg::ST_CONVERT);
    assign conv_channel = chan_idx_reg;
    assign conversion_irq_flag = irq_flag_reg;
    assign conversion_done = done_reg;
endmodule

// file: src/input_router.sv
// Maps set A or set B selections onto the four sample-and-hold inputs
`timescale 1ns/1ps
module input_router #(
    parameter int CHANS = 4
) (
    input wire logic clock,
    input wire logic soft_rst_n,
    input wire logic use_set_b,
    input wire logic [4:0] ch0_pos_select_a,
    input wire logic ch0_neg_select_a,
    input wire logic [4:0] ch0_pos_select_b,
    input wire logic ch0_neg_select_b,
    input wire logic trio_pos_select_a,
    input wire logic trio_pos_select_b,
    output logic [3*CHANS-1:0] sh_pos_input,
    output logic [CHANS-1:0] sh_pos_valid,
    output logic [CHANS-1:0] sh_neg_input1
);
    logic [4:0] ch0_pos;
    logic ch0_neg;
    logic trio_pos;

    assign ch0_pos = use_set_b ? ch0_pos_select_b : ch0_pos_select_a;
    assign ch0_neg = use_set_b ? ch0_neg_select_b : ch0_neg_select_a;
    assign trio_pos = use_set_b ? trio_pos_select_b : trio_pos_select_a;

    // Channel 0: value is the input number; neg 1 picks input 1
    always_ff @(posedge clock) begin
        if (!soft_rst_n) begin
            sh_pos_input[2:0] <= 3'h0;
            sh_pos_valid[0] <= 1'b1;
            sh_neg_input1[0] <= 1'b0;
        end else begin
            sh_pos_input[2:0] <= ch0_pos[2:0];
            sh_pos_valid[0] <= (ch0_pos < 5'h06);
            sh_neg_input1[0] <= ch0_neg;
        end
    end

    // Channels 1..3: inputs k-1 or k+2, negatives always ground
    genvar k;
    generate
        for (k = 1; k < CHANS; k++) begin : g_trio
            always_ff @(posedge clock) begin
                if (!soft_rst_n) begin
                    sh_pos_input[3*k +: 3] <= 3'(k - 1);
                    sh_pos_valid[k] <= 1'b1;
                    sh_neg_input1[k] <= 1'b0;
                end else begin
                    sh_pos_input[3*k +: 3] <= trio_pos ? 3'(k + 2)
                                                       : 3'(k - 1);
                    sh_pos_valid[k] <= 1'b1;
                    sh_neg_input1[k] <= 1'b0;
                end
            end
        end
    endgenerate
endmodule

// file: src/result_buffer.sv
// Result word store with one write port and one read port
`timescale 1ns/1ps
module result_buffer #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 16,
    parameter int PTR_W = 4
) (
    input wire logic clock,
    input wire logic soft_rst_n,
    input wire logic write_en,
    input wire logic [PTR_W-1:0] write_index,
    input wire logic [WIDTH-1:0] write_data,
    input wire logic [PTR_W-1:0] read_index,
    output logic [WIDTH-1:0] read_data
);
    logic [WIDTH-1:0] words [DEPTH];

    always_ff @(posedge clock) begin
        if (!soft_rst_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                words[i] <= '0;
            end
        end else if (write_en) begin
            words[write_index] <= write_data;
        end
    end

    assign read_data = words[read_index];
endmodule

// file: testbench/adc_sequencer_checker.sv
// Port-level assertions for the converter sequencer
`timescale 1ns/1ps
module adc_sequencer_checker (
    input logic clock,
    input logic reset_n,
    input logic converter_power_down,
    input logic [5:0] reg_addr,
    input logic [15:0] reg_wdata,
    input logic reg_write,
    input logic conv_trigger,
    input logic conv_done,
    input logic conv_active,
    input logic [1:0] conv_channel,
    input logic [5:0] pin_analog_en,
    input logic conversion_irq_flag,
    input logic conversion_done
);
    logic on_q, sm_q, hit;
    logic [1:0] cs_q;
    logic [3:0] f_q;
    logic [6:0] cnt_q, tgt;
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    assign hit = conv_done && conv_active;
    assign tgt = (7'(f_q) + 7'd1) * (!sm_q || cs_q == 2'b00 ? 7'd1 :
        cs_q == 2'b01 ? 7'd2 : 7'd4);
    always_ff @(posedge clock) begin
        if (!reset_n || converter_power_down) begin
            on_q <= 1'b0;
            sm_q <= 1'b0;
            cs_q <= 2'b00;
            f_q <= 4'h0;
        end else if (reg_write && reg_addr == 6'h00) begin
            on_q <= reg_wdata[15];
            sm_q <= reg_wdata[3];
        end else if (reg_write && reg_addr == 6'h01) begin
            cs_q <= reg_wdata[9:8];
            f_q <= reg_wdata[5:2];
        end
    end
    always_ff @(posedge clock) begin
        if (!reset_n || converter_power_down) begin
            cnt_q <= 7'd0;
        end else if (hit) begin
            cnt_q <= (cnt_q + 7'd1 == tgt) ? 7'd0 : cnt_q + 7'd1;
        end
    end
    property p_start;
        conv_trigger && !conv_active && on_q && !converter_power_down
            |=> conv_active && !conversion_done;
    endproperty
    a_start: assert property (p_start)
        else $error("no start");
    property p_off_stop;
        reg_write && reg_addr == 6'h00 && !reg_wdata[15]
            |=> ##1 !conv_active[*2];
    endproperty
    a_off_stop: assert property (p_off_stop)
        else $error("active when off");
    property p_pd_pins;
        converter_power_down
            |=> pin_analog_en == 6'h00 && !conversion_irq_flag && !conv_active;
    endproperty
    a_pd_pins: assert property (p_pd_pins)
        else $error("pins not digital");
    property p_pd_release;
        $fell(converter_power_down)
            |=> pin_analog_en == 6'h3f && !conversion_done;
    endproperty
    a_pd_release: assert property (p_pd_release)
        else $error("not default");
    property p_irq_sticky;
        conversion_irq_flag && !converter_power_down
            && !(reg_write && reg_addr == 6'h05 && reg_wdata[0])
            |=> conversion_irq_flag;
    endproperty
    a_irq_sticky: assert property (p_irq_sticky)
        else $error("flag dropped");
    property p_done_irq;
        $rose(conversion_done) |-> conversion_irq_flag;
    endproperty
    a_done_irq: assert property (p_done_irq)
        else $error("done alone");
    property p_irq_count;
        hit && cnt_q + 7'd1 == tgt |=> conversion_irq_flag && conversion_done;
    endproperty
    a_irq_count: assert property (p_irq_count)
        else $error("no interrupt");
    property p_chan_step;
        hit |=> !conv_active || conv_channel == $past(conv_channel) + 2'd1;
    endproperty
    a_chan_step: assert property (p_chan_step)
        else $error("no step");
    c_irq: cover property ($rose(conversion_irq_flag));
    c_abort: cover property (conv_active && reg_write && reg_addr == 6'h00);
    c_pd: cover property ($fell(converter_power_down));
endmodule

bind adc_sequencer adc_sequencer_checker u_checker (.*);

// file: testbench/adc_sequencer_tb_top.sv
// Self-checking testbench for the converter sequencer
`timescale 1ns/1ps
module adc_sequencer_tb_top;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic converter_power_down = 1'b0;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic conv_trigger = 1'b0;
    logic [5:0] reg_addr = 6'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic [2:0] lat = 3'h0;
    logic [15:0] reg_rdata, v;
    logic conv_done, conv_active, conversion_irq_flag, conversion_done, act;
    logic [9:0] conv_result;
    logic [1:0] conv_channel, cs;
    logic [11:0] sh_pos_input;
    logic [3:0] sh_pos_valid, sh_neg_input1, f, fm;
    logic [5:0] pin_analog_en;
    logic [2:0] p;
    int miscompares = 0, total_checks = 0, ndone = 0;
    int seed = 32'h6425;
    int md, nres;
    adc_sequencer dut (.*);
    analog_core_model far_side (.*);
    always #5 clock = ~clock;
    always @(posedge clock)
        if (conv_done && conv_active) ndone <= ndone + 1;
    function automatic logic [15:0] exp_res(input int k);
        return {6'h00, 10'(k * 59) ^ 10'h2a5};
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] a, input logic [15:0] e);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask
    task automatic conv(output logic started);
        @(posedge clock);
        lat <= 3'($random(seed));
        conv_trigger <= 1'b1;
        @(posedge clock);
        conv_trigger <= 1'b0;
        #1 started = conv_active;
        for (int i = 0; i < 80 && conv_active; i++) begin
            @(posedge clock);
            #1;
        end
    endtask
    task automatic cfg(input logic [1:0] c, input logic sm,
        input logic [3:0] fv, input logic sp, input logic al);
        wr(6'h00, 16'h0000);
        wr(6'h01, {6'h00, c, 2'b00, fv, sp, al});
        wr(6'h00, {12'h800, sm, 3'h0});
        rd(6'h01, {6'h00, c, 2'b00, fv, sp, al});
    endtask
    task automatic run(input int ntr, input int nr, input int wb);
        int base;
        base = ndone;
        for (int i = 0; i < ntr; i++) begin
            chk(16'(conversion_irq_flag), 16'h0000);
            conv(act);
        end
        chk({14'h0, conversion_irq_flag, conversion_done}, 16'h0003);
        for (int i = 0; i < nr; i++)
            rd(6'(16 + wb + i), exp_res(base + i));
        wr(6'h05, 16'h0001);
    endtask
    task close_out;
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        #400000;
        miscompares++;
        close_out;
    end
    initial begin
        repeat (12) @(posedge clock);
        reset_n <= 1'b1;
        for (int a = 0; a < 6; a++) rd(6'(a), 16'h0000);
        wr(6'h08, 16'hffff);
        rd(6'h08, 16'h0000);
        chk({4'h0, sh_pos_input}, 16'h0440);
        chk({10'h0, pin_analog_en}, 16'h003f);
        for (int m = 0; m < 10; m++) begin
            md = m % 5;
            cs = 2'(md > 2 ? md - 2 : md);
            fm = md < 3 ? 4'hf : (md == 3 ? 4'h7 : 4'h3);
            f = m < 5 ? fm : 4'($random(seed)) & fm;
            cfg(cs, md > 2, f, 1'b0, 1'b0);
            nres = (f + 1) * (md > 2 ? 2 * cs : 1);
            run(f + 1, nres, 0);
        end
        cfg(2'b00, 1'b0, 4'h1, 1'b0, 1'b0);
        @(posedge clock);
        lat <= 3'h7;
        conv_trigger <= 1'b1;
        @(posedge clock);
        conv_trigger <= 1'b0;
        wr(6'h00, 16'h0000);
        @(posedge clock);
        #1 chk(16'(conv_active), 16'h0000);
        conv(act);
        chk(16'(act), 16'h0000);
        wr(6'h00, 16'h8000);
        run(2, 2, 0);
        f = 4'($random(seed)) & 4'h7;
        cfg(2'b00, 1'b0, f, 1'b1, 1'b0);
        run(f + 1, f + 1, 0);
        rd(6'h01, {8'h00, 2'b10, f, 2'b10});
        run(f + 1, f + 1, 8);
        rd(6'h01, {8'h00, 2'b00, f, 2'b10});
        cfg(2'b00, 1'b0, 4'h1, 1'b0, 1'b1);
        wr(6'h02, 16'h0503);
        @(posedge clock);
        #1 chk({13'h0, sh_pos_input[2:0]}, 16'h0003);
        conv(act);
        @(posedge clock);
        #1 chk({13'h0, sh_pos_input[2:0]}, 16'h0005);
        conv(act);
        @(posedge clock);
        #1 chk({13'h0, sh_pos_input[2:0]}, 16'h0003);
        wr(6'h05, 16'h0001);
        wr(6'h01, 16'h0000);
        repeat (6) begin
            v = 16'($random(seed));
            p = v[2:0];
            wr(6'h02, v & 16'h9f87);
            wr(6'h03, v & 16'h0707);
            @(posedge clock);
            #1 chk({7'h0, sh_pos_input[11:3]},
                {7'h0, v[0] ? 9'o543 : 9'o210});
            chk({8'h0, sh_pos_valid, sh_neg_input1},
                {8'h0, 3'h7, p < 6, 3'h0, v[7]});
            if (p < 6) chk({13'h0, sh_pos_input[2:0]}, {13'h0, p});
        end
        v = 16'($random(seed)) & 16'h003f;
        wr(6'h04, v);
        @(posedge clock);
        #1 chk({10'h0, pin_analog_en}, {10'h0, ~v[5:0]});
        @(posedge clock);
        converter_power_down <= 1'b1;
        repeat (3) @(posedge clock);
        #1 chk({10'h0, pin_analog_en}, 16'h0000);
        @(posedge clock);
        converter_power_down <= 1'b0;
        rd(6'h00, 16'h0000);
        rd(6'h04, 16'h0000);
        rd(6'h10, 16'h0000);
        chk({10'h0, pin_analog_en}, 16'h003f);
        close_out;
    end
endmodule

// file: testbench/analog_core_model.sv
// Behavioural analog core answering conversion requests
`timescale 1ns/1ps
module analog_core_model (
    input logic clock,
    input logic reset_n,
    input logic conv_active,
    input logic [2:0] lat,
    output logic conv_done,
    output logic [9:0] conv_result
);
    logic [2:0] cnt;
    int n;
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            cnt <= 3'h0;
            n <= 0;
            conv_done <= 1'b0;
            conv_result <= 10'h155;
        end else begin
            conv_done <= 1'b0;
            conv_result <= ~conv_result;
            if (conv_active && !conv_done) begin
                if (cnt >= lat) begin
                    conv_done <= 1'b1;
                    conv_result <= 10'(n * 59) ^ 10'h2a5;
                    n <= n + 1;
                    cnt <= 3'h0;
                end else begin
                    cnt <= cnt + 3'h1;
                end
            end else begin
                cnt <= 3'h0;
            end
        end
    end
endmodule
